// >>> design/pcsc_pkg.sv
// package for the clock synthesis control block: offsets, fields, reset values, counts
// assumes a single 200 MHz bus clock and an ahb-lite slave at word offsets
// Function
// - reference picked from two external inputs or routing; external pair switches with glitches
// - selected reference passes through an input divider before phase comparison
// - feedback taken from internal path, fabric routing or external pin, by configuration
// - feedback divider makes output frequency reference times feedback ratio; outputs here divide hclk, fbdiv only spaces feedback ticks for lock
// - four outputs, each with its own independent divider
// - each output divider accepts any integer from 1 to 128
// - all outputs reach primary tree; only primary and first secondary reach edge tree
// - each secondary output can be advanced or delayed against the primary output
// - phase offsets set by configuration or moved at run time by fabric ports; written offsets are only stored, fabric steps alone shift outputs
// - lock asserted once loop locks, deasserted whenever lock is lost
package pcsc_pkg;
  // register byte offsets
  localparam logic [7:0] PCSC_OFF_REFSEL  = 8'h00;
  localparam logic [7:0] PCSC_OFF_FBSEL   = 8'h04;
  localparam logic [7:0] PCSC_OFF_INDIV   = 8'h08;
  localparam logic [7:0] PCSC_OFF_FBDIV   = 8'h0C;
  localparam logic [7:0] PCSC_OFF_ODIV0   = 8'h10;
  localparam logic [7:0] PCSC_OFF_ODIV1   = 8'h14;
  localparam logic [7:0] PCSC_OFF_ODIV2   = 8'h18;
  localparam logic [7:0] PCSC_OFF_ODIV3   = 8'h1C;
  localparam logic [7:0] PCSC_OFF_ROUTE   = 8'h20;
  localparam logic [7:0] PCSC_OFF_PHASE1  = 8'h24;
  localparam logic [7:0] PCSC_OFF_PHASE2  = 8'h28;
  localparam logic [7:0] PCSC_OFF_PHASE3  = 8'h2C;
  localparam logic [7:0] PCSC_OFF_STATUS  = 8'h30;
  localparam logic [7:0] PCSC_OFF_IRQST   = 8'h34;
  localparam logic [7:0] PCSC_OFF_IRQMSK  = 8'h38;
  // divider field width; stored value is ratio minus one
  localparam int         PCSC_DIV_W       = 7;
  localparam int         PCSC_PH_W        = 8;
  localparam logic [6:0] PCSC_DIV_RST     = 7'h00;
  // route field: bits 3:0 primary tree enables, bits 5:4 edge tree enables
  localparam int         PCSC_RT_EDGE_LSB = 4;
  localparam logic [5:0] PCSC_ROUTE_RST   = 6'h0F;
  // feedback sources
  typedef enum logic [1:0] {
    PCSC_FB_INTERNAL = 2'h0,
    PCSC_FB_ROUTING  = 2'h1,
    PCSC_FB_PIN      = 2'h2
  } pcsc_fb_t;
  // reference sources
  typedef enum logic [1:0] {
    PCSC_REF_EXT0    = 2'h0,
    PCSC_REF_EXT1    = 2'h1,
    PCSC_REF_ROUTING = 2'h2
  } pcsc_ref_t;
  // lock detection timing
  localparam int         PCSC_CLK_MHZ     = 200;
  localparam int         PCSC_LOCK_NS     = 1000;
  localparam int         PCSC_LOCK_CYC    = (PCSC_LOCK_NS * PCSC_CLK_MHZ + 999) / 1000;
  localparam int         PCSC_CNT_W       = 8;
  // status and irq bits
  localparam int         PCSC_IRQ_LOCK    = 0;
  localparam int         PCSC_IRQ_UNLOCK  = 1;
  localparam int         PCSC_IRQ_PHASE   = 2;
endpackage

// >>> design/pcsc_div_if.sv
// carrier between the top and its divider leaves
// assumes one clock domain shared by every user
`timescale 1ns/1ps
interface pcsc_div_if;
  import pcsc_pkg::*;
  logic [PCSC_DIV_W-1:0] ratio_m1;
  logic                  tick_in;
  logic                  tick_out;
  modport ctl  (output ratio_m1, output tick_in, input tick_out);
  modport leaf (input ratio_m1, input tick_in, output tick_out);
endinterface

// >>> design/pcsc_divider.sv
// integer event divider: one output tick every ratio_m1+1 input ticks
// assumes ticks are one-cycle enables on hclk
`timescale 1ns/1ps
module pcsc_divider
  import pcsc_pkg::*;
(
  // clock and reset
  input  wire logic      hclk,
  input  wire logic      hresetn,
  // ratio and ticks
  pcsc_div_if.leaf       div
);
  logic [PCSC_DIV_W-1:0] cnt_r;
  logic [PCSC_DIV_W-1:0] cnt_nxt;
  logic                  out_r;
  logic                  out_nxt;

  // count input ticks, wrap at the ratio; any value 1..128 works
  always_comb
  begin
    cnt_nxt = cnt_r;
    out_nxt = 1'b0;
    if (div.tick_in)
    begin
      if (cnt_r >= div.ratio_m1)
      begin
        cnt_nxt = 7'h00;
        out_nxt = 1'b1;
      end
      else
        cnt_nxt = cnt_r + 7'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r <= 7'h00;
      out_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign div.tick_out = out_r;

  a_div_period: assert property (@(posedge hclk) disable iff (!hresetn)
    (div.tick_in && cnt_r == 7'h00 && div.ratio_m1 == 7'h00) |=> out_r)
    else $error("divider by one missed a tick");
endmodule

// >>> design/pcsc_top.sv
// clock synthesis control: source selection, dividers, routing, phase, lock
// assumes reference and feedback arrive as one-cycle event ticks on hclk
`timescale 1ns/1ps
module pcsc_top
  import pcsc_pkg::*;
#(
  parameter int NUM_OUT = 4
)
(
  // bus clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // reference and feedback ticks
  input  wire logic                  reference_clock_in_ext0,
  input  wire logic                  reference_clock_in_ext1,
  input  wire logic                  reference_clock_in_routing,
  input  wire logic                  feedback_clock_in_routing,
  input  wire logic                  feedback_clock_in_pin,
  // fabric phase control
  input  wire logic [1:0]            phase_output_select,
  input  wire logic                  phase_direction,
  input  wire logic                  phase_step_pulse,
  input  wire logic                  phase_load_strobe,
  // clocks and status
  output logic                       primary_clock_out,
  output logic                       first_secondary_clock_out,
  output logic                       second_secondary_clock_out,
  output logic                       third_secondary_clock_out,
  output logic [NUM_OUT-1:0]         primary_tree_out,
  output logic [1:0]                 edge_clock_tree,
  output logic                       lock,
  output logic                       irq
);
  import pcsc_pkg::*;

  typedef enum logic [2:0] {
    PCSC_LK_IDLE = 3'b001,
    PCSC_LK_WAIT = 3'b010,
    PCSC_LK_LOCK = 3'b100
  } pcsc_lk_t;

  // registers
  pcsc_ref_t             refsel_r, refsel_nxt;
  pcsc_fb_t              fbsel_r, fbsel_nxt;
  logic [PCSC_DIV_W-1:0] indiv_r, indiv_nxt, fbdiv_r, fbdiv_nxt;
  logic [PCSC_DIV_W-1:0] odiv_r [NUM_OUT];
  logic [PCSC_DIV_W-1:0] odiv_nxt [NUM_OUT];
  logic [5:0]            route_r, route_nxt;
  logic [PCSC_PH_W-1:0]  phase_r [1:3];
  logic [PCSC_PH_W-1:0]  phase_nxt [1:3];
  logic [2:0]            irqst_r, irqst_nxt, irqmsk_r, irqmsk_nxt;
  // bus address phase capture
  logic                  wr_pend_r, wr_pend_nxt, rd_pend_r, rd_pend_nxt;
  logic [7:0]            addr_r, addr_nxt;
  logic [31:0]           hrdata_nxt;
  // lock machine
  pcsc_lk_t              lk_r, lk_nxt;
  logic [PCSC_CNT_W-1:0] lkcnt_r, lkcnt_nxt;
  logic [PCSC_CNT_W-1:0] fbgap_r, fbgap_nxt;
  logic                  ev_lock, ev_unlock, ev_phase;
  // clock path
  logic                  ref_tick, fb_tick, pfd_ref, pfd_fb;
  logic [NUM_OUT-1:0]    otick;
  logic [NUM_OUT-1:0]    oclk_r, oclk_nxt;
  logic [NUM_OUT-1:0]    ptree_nxt, ostall;
  logic [1:0]            etree_nxt;

  // address phase decode that reads and writes both use
  function automatic logic bus_go(input logic s, input logic [1:0] t, input logic r);
    return s && t[1] && r;
  endfunction

  // reference mux: external pair switches immediately, no glitch protection
  always_comb
  begin
    case (refsel_r)
      PCSC_REF_EXT0:    ref_tick = reference_clock_in_ext0;
      PCSC_REF_EXT1:    ref_tick = reference_clock_in_ext1;
      PCSC_REF_ROUTING: ref_tick = reference_clock_in_routing;
      default:          ref_tick = reference_clock_in_ext0;
    endcase
  end

  // input divider ahead of comparison
  pcsc_div_if in_if ();
  assign in_if.ratio_m1 = indiv_r;
  assign in_if.tick_in  = ref_tick;
  assign pfd_ref        = in_if.tick_out;
  pcsc_divider u_indiv (.hclk(hclk), .hresetn(hresetn), .div(in_if.leaf));

  // the synthesized rate is not modelled; outputs run from hclk and fbdiv+1 only spaces the feedback ticks
  // internal feedback returns the primary output; others come from outside
  always_comb
  begin
    case (fbsel_r)
      PCSC_FB_INTERNAL: fb_tick = otick[0];
      PCSC_FB_ROUTING:  fb_tick = feedback_clock_in_routing;
      PCSC_FB_PIN:      fb_tick = feedback_clock_in_pin;
      default:          fb_tick = otick[0];
    endcase
  end

  pcsc_div_if fb_if ();
  assign fb_if.ratio_m1 = fbdiv_r;
  assign fb_if.tick_in  = fb_tick;
  assign pfd_fb         = fb_if.tick_out;
  pcsc_divider u_fbdiv (.hclk(hclk), .hresetn(hresetn), .div(fb_if.leaf));

  // four independent output dividers, fed from hclk as vco stand-in
  pcsc_div_if o_if [NUM_OUT] ();
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++)
    begin : g_out
      assign o_if[g].ratio_m1 = odiv_r[g];
      assign o_if[g].tick_in  = ~ostall[g];
      assign otick[g]         = o_if[g].tick_out;
      pcsc_divider u_odiv (.hclk(hclk), .hresetn(hresetn), .div(o_if[g].leaf));
    end
  endgenerate

  // output toggles; phase steps act on the dividers, one hclk cycle each
  always_comb
  begin
    oclk_nxt = oclk_r;
    for (int i = 0; i < NUM_OUT; i++)
      if (otick[i])
        oclk_nxt[i] = ~oclk_r[i];
    ptree_nxt = oclk_nxt & route_r[NUM_OUT-1:0];
    etree_nxt = oclk_nxt[1:0] & route_r[PCSC_RT_EDGE_LSB+:2];
  end

  // a delay stalls the chosen divider a cycle; an advance stalls all others,
  // so only the chosen output moves against the primary
  always_comb
  begin
    for (int i = 0; i < NUM_OUT; i++)
      ostall[i] = phase_step_pulse && phase_output_select != 2'h0 &&
        ((int'(phase_output_select) == i) == phase_direction);
  end

  // lock: a divided reference tick starts 200 cycles of waiting with no long feedback gap; lost on long feedback gap
  always_comb
  begin
    lk_nxt    = lk_r;
    lkcnt_nxt = lkcnt_r;
    fbgap_nxt = pfd_fb ? 8'h00 : ((fbgap_r == 8'hFF) ? fbgap_r : fbgap_r + 8'h01);
    ev_lock   = 1'b0;
    ev_unlock = 1'b0;
    case (lk_r)
      PCSC_LK_IDLE:
      begin
        lkcnt_nxt = 8'h00;
        if (pfd_ref)
          lk_nxt = PCSC_LK_WAIT;
      end
      PCSC_LK_WAIT:
      begin
        if (fbgap_r == 8'hFF)
          lk_nxt = PCSC_LK_IDLE;
        else if (lkcnt_r >= 8'(PCSC_LOCK_CYC - 1))
        begin
          lk_nxt  = PCSC_LK_LOCK;
          ev_lock = 1'b1;
        end
        else
          lkcnt_nxt = lkcnt_r + 8'h01;
      end
      PCSC_LK_LOCK:
      begin
        if (fbgap_r == 8'hFF)
        begin
          lk_nxt    = PCSC_LK_IDLE;
          ev_unlock = 1'b1;
        end
      end
      default: lk_nxt = PCSC_LK_IDLE;
    endcase
    // a reference change forces a fresh search, even one half done on the old source
    if (wr_pend_r && addr_r == PCSC_OFF_REFSEL)
    begin
      lk_nxt    = PCSC_LK_IDLE;
      ev_lock   = 1'b0;
      ev_unlock = (lk_r == PCSC_LK_LOCK);
    end
  end

  // ahb-lite: zero wait state, writes land in the data phase
  always_comb
  begin
    wr_pend_nxt = bus_go(hsel, htrans, hready) && hwrite;
    rd_pend_nxt = bus_go(hsel, htrans, hready) && !hwrite;
    addr_nxt    = bus_go(hsel, htrans, hready) ? haddr : addr_r;
    refsel_nxt  = refsel_r;
    fbsel_nxt   = fbsel_r;
    indiv_nxt   = indiv_r;
    fbdiv_nxt   = fbdiv_r;
    odiv_nxt    = odiv_r;
    route_nxt   = route_r;
    phase_nxt   = phase_r;
    irqmsk_nxt  = irqmsk_r;
    irqst_nxt   = irqst_r;
    ev_phase    = phase_step_pulse || phase_load_strobe;
    // fabric step moves the selected offset one increment
    if (phase_step_pulse && phase_output_select != 2'h0)
      phase_nxt[phase_output_select] = phase_direction ?
        phase_r[phase_output_select] + 8'h01 : phase_r[phase_output_select] - 8'h01;
    // load strobe clears the selected secondary's offset to zero
    if (phase_load_strobe && phase_output_select != 2'h0)
      phase_nxt[phase_output_select] = 8'h00;
    if (wr_pend_r)
    begin
      case (addr_r)
        PCSC_OFF_REFSEL: refsel_nxt = pcsc_ref_t'(hwdata[1:0]);
        PCSC_OFF_FBSEL:  fbsel_nxt  = pcsc_fb_t'(hwdata[1:0]);
        PCSC_OFF_INDIV:  indiv_nxt  = hwdata[6:0];
        PCSC_OFF_FBDIV:  fbdiv_nxt  = hwdata[6:0];
        PCSC_OFF_ODIV0:  odiv_nxt[0] = hwdata[6:0];
        PCSC_OFF_ODIV1:  odiv_nxt[1] = hwdata[6:0];
        PCSC_OFF_ODIV2:  odiv_nxt[2] = hwdata[6:0];
        PCSC_OFF_ODIV3:  odiv_nxt[3] = hwdata[6:0];
        PCSC_OFF_ROUTE:  route_nxt  = hwdata[5:0];
        PCSC_OFF_PHASE1: phase_nxt[1] = hwdata[7:0];
        PCSC_OFF_PHASE2: phase_nxt[2] = hwdata[7:0];
        PCSC_OFF_PHASE3: phase_nxt[3] = hwdata[7:0];
        PCSC_OFF_IRQST:  irqst_nxt  = irqst_r & ~hwdata[2:0];
        PCSC_OFF_IRQMSK: irqmsk_nxt = hwdata[2:0];
        default:         ;
      endcase
    end
    // hardware set wins over the write-one clear
    irqst_nxt[PCSC_IRQ_LOCK]   = irqst_nxt[PCSC_IRQ_LOCK] | ev_lock;
    irqst_nxt[PCSC_IRQ_UNLOCK] = irqst_nxt[PCSC_IRQ_UNLOCK] | ev_unlock;
    irqst_nxt[PCSC_IRQ_PHASE]  = irqst_nxt[PCSC_IRQ_PHASE] | ev_phase;
    case (haddr)
      PCSC_OFF_REFSEL: hrdata_nxt = {30'h0, refsel_nxt};
      PCSC_OFF_FBSEL:  hrdata_nxt = {30'h0, fbsel_nxt};
      PCSC_OFF_INDIV:  hrdata_nxt = {25'h0, indiv_nxt};
      PCSC_OFF_FBDIV:  hrdata_nxt = {25'h0, fbdiv_nxt};
      PCSC_OFF_ODIV0:  hrdata_nxt = {25'h0, odiv_nxt[0]};
      PCSC_OFF_ODIV1:  hrdata_nxt = {25'h0, odiv_nxt[1]};
      PCSC_OFF_ODIV2:  hrdata_nxt = {25'h0, odiv_nxt[2]};
      PCSC_OFF_ODIV3:  hrdata_nxt = {25'h0, odiv_nxt[3]};
      PCSC_OFF_ROUTE:  hrdata_nxt = {26'h0, route_nxt};
      PCSC_OFF_PHASE1: hrdata_nxt = {24'h0, phase_nxt[1]};
      PCSC_OFF_PHASE2: hrdata_nxt = {24'h0, phase_nxt[2]};
      PCSC_OFF_PHASE3: hrdata_nxt = {24'h0, phase_nxt[3]};
      PCSC_OFF_STATUS: hrdata_nxt = {29'h0, lk_nxt};
      PCSC_OFF_IRQST:  hrdata_nxt = {29'h0, irqst_nxt};
      PCSC_OFF_IRQMSK: hrdata_nxt = {29'h0, irqmsk_nxt};
      default:         hrdata_nxt = 32'h0000_0000;
    endcase
    if (!rd_pend_nxt)
      hrdata_nxt = 32'h0000_0000;
  end

  // register everything; outputs except the tied hreadyout and hresp leave straight from flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      refsel_r  <= PCSC_REF_EXT0;
      fbsel_r   <= PCSC_FB_INTERNAL;
      indiv_r   <= PCSC_DIV_RST;
      fbdiv_r   <= PCSC_DIV_RST;
      for (int i = 0; i < NUM_OUT; i++)
        odiv_r[i] <= PCSC_DIV_RST;
      route_r   <= PCSC_ROUTE_RST;
      for (int i = 1; i < 4; i++)
        phase_r[i] <= 8'h00;
      irqst_r   <= 3'h0;
      irqmsk_r  <= 3'h0;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      lk_r      <= PCSC_LK_IDLE;
      lkcnt_r   <= 8'h00;
      fbgap_r   <= 8'h00;
      oclk_r    <= '0;
      primary_tree_out <= '0;
      edge_clock_tree  <= 2'h0;
      lock      <= 1'b0;
      irq       <= 1'b0;
    end
    else
    begin
      refsel_r  <= refsel_nxt;
      fbsel_r   <= fbsel_nxt;
      indiv_r   <= indiv_nxt;
      fbdiv_r   <= fbdiv_nxt;
      odiv_r    <= odiv_nxt;
      route_r   <= route_nxt;
      phase_r   <= phase_nxt;
      irqst_r   <= irqst_nxt;
      irqmsk_r  <= irqmsk_nxt;
      wr_pend_r <= wr_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      addr_r    <= addr_nxt;
      hrdata    <= hrdata_nxt;
      lk_r      <= lk_nxt;
      lkcnt_r   <= lkcnt_nxt;
      fbgap_r   <= fbgap_nxt;
      oclk_r    <= oclk_nxt;
      primary_tree_out <= ptree_nxt;
      edge_clock_tree  <= etree_nxt;
      lock      <= (lk_nxt == PCSC_LK_LOCK);
      irq       <= |(irqst_nxt & irqmsk_nxt);
    end
  end

  assign hreadyout                  = 1'b1;
  assign hresp                      = 1'b0;
  assign primary_clock_out          = oclk_r[0];
  assign first_secondary_clock_out  = oclk_r[1];
  assign second_secondary_clock_out = oclk_r[2];
  assign third_secondary_clock_out  = oclk_r[3];

  a_lock_state: assert property (@(posedge hclk) disable iff (!hresetn)
    lock == (lk_r == PCSC_LK_LOCK))
    else $error("lock output disagrees with lock state");
  a_lock_loss: assert property (@(posedge hclk) disable iff (!hresetn)
    (lk_r == PCSC_LK_LOCK && fbgap_r == 8'hFF) |=> !lock)
    else $error("lock held after feedback loss");
  a_edge_route: assert property (@(posedge hclk) disable iff (!hresetn)
    !route_r[PCSC_RT_EDGE_LSB] |=> !edge_clock_tree[0])
    else $error("edge tree driven while disabled");
  a_step_move: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_step_pulse && !phase_load_strobe && !wr_pend_r && phase_output_select == 2'h1
     && phase_direction) |=> phase_r[1] == $past(phase_r[1]) + 8'h01)
    else $error("phase step did not advance offset");
  a_step_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (phase_step_pulse && phase_direction && phase_output_select == 2'h2)
    |=> g_out[2].u_odiv.cnt_r == $past(g_out[2].u_odiv.cnt_r))
    else $error("delay step did not stall its divider");
  a_ref_mux: assert property (@(posedge hclk) disable iff (!hresetn)
    (refsel_r == PCSC_REF_EXT1) |-> ref_tick == reference_clock_in_ext1)
    else $error("reference mux wrong source");
  a_fb_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    (fbsel_r == PCSC_FB_PIN) |-> fb_tick == feedback_clock_in_pin)
    else $error("feedback mux wrong source");
  a_refsel_relock: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && addr_r == PCSC_OFF_REFSEL) |=> !lock)
    else $error("lock kept over reference change");
  c_lock: cover property (@(posedge hclk) disable iff (!hresetn) $rose(lock));
  c_unlock: cover property (@(posedge hclk) disable iff (!hresetn) $fell(lock));
  c_step: cover property (@(posedge hclk) disable iff (!hresetn)
    phase_step_pulse && phase_output_select == 2'h3);
endmodule

// >>> bench/pcsc_fabric_model.sv
// fabric-side model: reference and feedback ticks, run-time phase control
// assumes the block's hclk; every tick is a one-cycle pulse
`timescale 1ns/1ps
module pcsc_fabric_model
(
  // clock, reset and scenario selects
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [1:0] ref_src,
  input  wire logic [1:0] fb_src,
  // ticks toward the block
  output logic            ref_ext0,
  output logic            ref_ext1,
  output logic            ref_routing,
  output logic            fb_routing,
  output logic            fb_pin,
  // phase control toward the block
  output logic [1:0]      phase_output_select,
  output logic            phase_direction,
  output logic            phase_step_pulse,
  output logic            phase_load_strobe
);
  logic [3:0] cnt_r;
  // free counter; reference every 16 cycles, feedback every 4
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_r <= 4'h0;
    else
      cnt_r <= cnt_r + 4'h1;
  end
  // only the chosen source ticks, so a wrong mux pick starves the loop
  assign ref_ext0    = (cnt_r == 4'h0) && (ref_src == 2'h0);
  assign ref_ext1    = (cnt_r == 4'h0) && (ref_src == 2'h1);
  assign ref_routing = (cnt_r == 4'h0) && (ref_src == 2'h2);
  assign fb_routing  = (cnt_r[1:0] == 2'h0) && (fb_src == 2'h1);
  assign fb_pin      = (cnt_r[1:0] == 2'h0) && (fb_src == 2'h2);
  // phase port levels at time zero
  initial
  begin
    phase_output_select = 2'h0;
    phase_direction     = 1'b0;
    phase_step_pulse    = 1'b0;
    phase_load_strobe   = 1'b0;
  end
  // one step or load pulse; select and direction stand with it and after
  task automatic phase_op(input logic [1:0] sel, input logic dir, input logic ld);
    @(posedge hclk);
    phase_output_select <= sel;
    phase_direction     <= dir;
    phase_step_pulse    <= ~ld;
    phase_load_strobe   <= ld;
    @(posedge hclk);
    phase_step_pulse    <= 1'b0;
    phase_load_strobe   <= 1'b0;
  endtask
endmodule

// >>> bench/test_pcsc_top.sv
// self-checking bench for the clock synthesis control block
// assumes an always-ready ahb-lite slave and the fabric model beside it
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_pcsc_top;
  import pcsc_pkg::*;
  // bus and reset
  logic        hclk, hresetn, hsel, hwrite;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, rd;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp;
  // fabric side and outputs
  logic [1:0]  ref_src, fb_src;
  wire         r0, r1, r2, f0, f1, pdir, pstep, pload, lock, irq;
  wire  [1:0]  psel, etree;
  wire  [3:0]  clks, ptree;
  logic [3:0]  seen_p;
  logic [1:0]  seen_e;
  logic        seen;
  int          failures, compares, cycles, p, d0, d1, d2;
  int          ratio [3] = '{128, 3, 1};
  logic [5:0]  route [3] = '{6'h21, 6'h12, 6'h00};

  pcsc_top #(.NUM_OUT(4)) pcsc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .reference_clock_in_ext0(r0), .reference_clock_in_ext1(r1),
    .reference_clock_in_routing(r2), .feedback_clock_in_routing(f0),
    .feedback_clock_in_pin(f1), .phase_output_select(psel), .phase_direction(pdir),
    .phase_step_pulse(pstep), .phase_load_strobe(pload), .primary_clock_out(clks[0]),
    .first_secondary_clock_out(clks[1]), .second_secondary_clock_out(clks[2]),
    .third_secondary_clock_out(clks[3]), .primary_tree_out(ptree),
    .edge_clock_tree(etree), .lock(lock), .irq(irq));
  pcsc_fabric_model pcsc_fabric_model_inst (.hclk(hclk), .hresetn(hresetn),
    .ref_src(ref_src), .fb_src(fb_src), .ref_ext0(r0), .ref_ext1(r1), .ref_routing(r2),
    .fb_routing(f0), .fb_pin(f1), .phase_output_select(psel), .phase_direction(pdir),
    .phase_step_pulse(pstep), .phase_load_strobe(pload));

  // 200 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // watchdog; the run needs roughly 5500 cycles
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one single transfer; the address phase holds until ready is seen
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic wait_lock(input logic v, input int lim);
    for (int n = 0; n < lim && lock !== v; n++)
      @(posedge hclk);
  endtask
  // cycles between rising samples of one output, after two syncs
  task automatic period(input int i, output int q);
    repeat (3)
    begin
      q = 0;
      while (clks[i] !== 1'b0 && q < 600) begin @(posedge hclk); q++; end
      while (clks[i] !== 1'b1 && q < 600) begin @(posedge hclk); q++; end
    end
  endtask
  // distance from a primary rise to the next rise of output i
  task automatic rel(input int i, output int q);
    period(0, q);
    q = 0;
    while (clks[i] !== 1'b0) begin @(posedge hclk); q++; end
    while (clks[i] !== 1'b1) begin @(posedge hclk); q++; end
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 8'h00;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    ref_src = 2'h0;
    fb_src  = 2'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, field widths and an unmapped word
    chk_rd(PCSC_OFF_ROUTE, 32'h0000000F);
    wr(8'h3C, 32'hFFFFFFFF);
    chk_rd(8'h3C, 32'h00000000);
    wr(PCSC_OFF_ODIV2, 32'hFFFFFF84);
    chk_rd(PCSC_OFF_ODIV2, 32'h00000004);
    wr(PCSC_OFF_FBDIV, 32'h7F);
    chk_rd(PCSC_OFF_FBDIV, 32'h7F);
    // independent dividers; odiv0 swept to both ends of its range
    wr(PCSC_OFF_ODIV1, 32'h2);
    foreach (ratio[k])
    begin
      wr(PCSC_OFF_ODIV0, 32'(ratio[k] - 1));
      period(0, p); `CHK(p, 2 * ratio[k])
      period(1, p); `CHK(p, 6)
      period(2, p); `CHK(p, 10)
      period(3, p); `CHK(p, 2)
    end
    // routing; only two edge tree bits exist
    wr(PCSC_OFF_ROUTE, 32'hFF);
    chk_rd(PCSC_OFF_ROUTE, 32'h3F);
    foreach (route[k])
    begin
      wr(PCSC_OFF_ROUTE, 32'(route[k]));
      repeat (2) @(posedge hclk);
      seen_p = 4'h0;
      seen_e = 2'h0;
      repeat (40) begin @(posedge hclk); seen_p |= ptree; seen_e |= etree; end
      `CHK(seen_p, route[k][3:0])
      `CHK(seen_e, route[k][5:4])
    end
    // lock, its interrupt bits, loss on a reference rewrite
    wait_lock(1'b1, 1000); `CHK(lock, 1'b1)
    wr(PCSC_OFF_IRQMSK, 32'h1);
    wr(PCSC_OFF_IRQST, 32'h7);
    wr(PCSC_OFF_REFSEL, 32'h0);
    wait_lock(1'b0, 4); `CHK(lock, 1'b0)
    wait_lock(1'b1, 1000); `CHK(lock, 1'b1)
    repeat (2) @(posedge hclk);
    `CHK(irq, 1'b1)
    chk_rd(PCSC_OFF_IRQST, 32'h3);
    wr(PCSC_OFF_IRQST, 32'h1);
    chk_rd(PCSC_OFF_IRQST, 32'h2);
    repeat (2) @(posedge hclk);
    `CHK(irq, 1'b0)
    wr(PCSC_OFF_IRQMSK, 32'h2);
    repeat (2) @(posedge hclk);
    `CHK(irq, 1'b1)
    wr(PCSC_OFF_IRQST, 32'h2);
    repeat (2) @(posedge hclk);
    `CHK(irq, 1'b0)
    // every reference source behind the input divider; wrong input never locks
    wr(PCSC_OFF_INDIV, 32'h3);
    chk_rd(PCSC_OFF_INDIV, 32'h3);
    for (int s = 0; s < 3; s++)
    begin
      ref_src <= 2'((s + 1) % 3);
      wr(PCSC_OFF_REFSEL, 32'(s));
      repeat (3) @(posedge hclk);
      seen = 1'b0;
      repeat (600) begin @(posedge hclk); seen |= lock; end
      `CHK(seen, 1'b0)
      ref_src <= 2'(s);
      wait_lock(1'b1, 1000); `CHK(lock, 1'b1)
    end
    // external feedback sources; starving the chosen one drops lock
    wr(PCSC_OFF_FBDIV, 32'h3);
    for (int f = 1; f < 3; f++)
    begin
      fb_src <= 2'(f);
      wr(PCSC_OFF_FBSEL, 32'(f));
      wait_lock(1'b1, 1000); `CHK(lock, 1'b1)
      fb_src <= 2'(3 - f);
      wait_lock(1'b0, 300); `CHK(lock, 1'b0)
    end
    wr(PCSC_OFF_FBSEL, 32'h0);
    wait_lock(1'b1, 1000); `CHK(lock, 1'b1)
    // phase steps against the primary output, all dividers at 4
    for (int i = 0; i < 4; i++)
      wr(PCSC_OFF_ODIV0 + 8'(4 * i), 32'h3);
    for (int i = 1; i < 4; i++)
    begin
      rel(i, d0);
      pcsc_fabric_model_inst.phase_op(2'(i), 1'b1, 1'b0);
      pcsc_fabric_model_inst.phase_op(2'(i), 1'b1, 1'b0);
      rel(i, d1); `CHK((d1 - d0 + 8) % 8, 2)
      pcsc_fabric_model_inst.phase_op(2'(i), 1'b0, 1'b0);
      rel(i, d2); `CHK((d2 - d1 + 8) % 8, 7)
      chk_rd(PCSC_OFF_PHASE1 + 8'(4 * i - 4), 32'h1);
      pcsc_fabric_model_inst.phase_op(2'(i), 1'b1, 1'b1);
      chk_rd(PCSC_OFF_PHASE1 + 8'(4 * i - 4), 32'h0);
    end
    bus(PCSC_OFF_IRQST, 1'b0, 32'h0); `CHK(rd[2], 1'b1)
    pcsc_fabric_model_inst.phase_op(2'h0, 1'b1, 1'b0);
    chk_rd(PCSC_OFF_PHASE1, 32'h0);
    wr(PCSC_OFF_PHASE2, 32'h5);
    chk_rd(PCSC_OFF_PHASE2, 32'h5);
    stop_test();
  end
endmodule
